// File: logic/lnbsc_pkg.sv
// package: constants and types for the supply control register block
package lnbsc_pkg;
  // bit positions within the system control register
  localparam int BIT_SUPPLY_EN = 0;
  localparam int BIT_LEVEL_SEL = 1;
  localparam int BIT_BOOST = 2;
  localparam int BIT_TONE_ON = 3;
  localparam int BIT_CUR_SEL = 4;
  localparam int BIT_PULSE_MODE = 5;
  localparam int BIT_OVERLOAD = 6;
  localparam int BIT_OVERTEMP = 7;
  localparam logic [7:0] CTRL_MASK = 8'h3f;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // register offset on the plain register port
  localparam logic [3:0] ADDR_SYS = 4'h0;
  // two-bit address-select straps, each picks a bus address
  localparam logic [6:0] BASE_ADDR = 7'h04;
  // pulsed limit timing
  localparam longint CLK_HZ = 200000000;
  localparam longint T_OFF_MS = 900;
  localparam longint T_ON_MS = 90;
  localparam longint OFF_CYC = T_OFF_MS * CLK_HZ / 1000;
  localparam longint ON_CYC = T_ON_MS * CLK_HZ / 1000;
  localparam int CNT_W = 28;
  typedef enum logic [1:0] {
    LNBSC_IDLE = 2'b00,
    LNBSC_OFF = 2'b01,
    LNBSC_ON = 2'b11
  } lnbsc_pulse_e;
  // control settings as the analog blocks see them
  typedef struct packed {
    logic power_on;
    logic loop_closed;
    logic level_18v;
    logic boost_1v;
    logic low_current;
    logic tone_out;
  } lnbsc_drive_s;
endpackage

// File: logic/lnbsc_top.sv
// system control register, serial slave, pulsed limit timer
//
// Overview of operation
// - one eight-bit register, six control bits
// - readback returns control plus two status bits
// - enable low: standby, power off, loop closed
// - level select picks 13 V or 18 V
// - boost bit adds one volt
// - serial bit or key pin drives tone
// - tone-force bit gives continuous tone
// - detector data presented on detect pin
// - current-select bit picks overload threshold
// - pulsed overload: 900 ms off, flag set
// - then on for one tenth of off
// - repeat while overloaded, else clear flag
// - internal timer sets off and on times
// - static mode flag follows current clamp
// - overtemperature: shut off, open loop, flag
// - cooled down: resume, clear flag
// - undervoltage lockout disables all functions
// - detect output driven low on tone
// - serial byte eight bits msb first, ack
// - four addresses selected by address pins
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module lnbsc_top
  import lnbsc_pkg::*;
#(
  parameter longint OFF_CYCLES = OFF_CYC,
  parameter longint ON_CYCLES = ON_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_select,
  input wire logic tone_key_input,
  input wire logic tone_detector_input,
  input wire logic overload_sense,
  input wire logic overtemp_sense,
  input wire logic undervolt_sense,
  output logic tone_detect_output,
  output logic tone_detect_oe,
  output lnbsc_drive_s drive
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: the first stage is read only by the second
  localparam int NSYNC = 8;
  // serial lines rest high, so they reset high: no false edge after reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 8'hc0;
  logic [NSYNC-1:0] s1;
  logic [NSYNC-1:0] s2;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1 <= SYNC_IDLE;
      s2 <= SYNC_IDLE;
    end else begin
      s1 <= {scl_in, sda_in, addr_select, tone_key_input, tone_detector_input,
             overload_sense, overtemp_sense};
      s2 <= s1;
    end
  end
  logic scl_s, sda_s, key_s, det_s, ovl_s, otp_s;
  logic [1:0] adsel_s;
  assign {scl_s, sda_s, adsel_s, key_s, det_s, ovl_s, otp_s} = s2;
  // undervoltage passes the same two stages
  logic uv1, uv_s;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      uv1 <= 1'b0;
      uv_s <= 1'b0;
    end else begin
      uv1 <= undervolt_sense;
      uv_s <= uv1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // serial slave: edges of scl and sda seen on the system clock
  typedef enum logic [2:0] {
    LNBSC_S_IDLE = 3'b000,
    LNBSC_S_ADDR = 3'b001,
    LNBSC_S_ACK = 3'b011,
    LNBSC_S_WR = 3'b010,
    LNBSC_S_RD = 3'b110,
    LNBSC_S_RACK = 3'b111
  } lnbsc_ser_e;
  lnbsc_ser_e st, next_st;
  logic scl_d, sda_d;
  logic [7:0] shift, next_shift;
  logic [3:0] nbit, next_nbit;
  logic rd_mode, next_rd_mode;
  logic sda_drv, next_sda_drv;
  logic ser_wr, next_ser_wr;
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] status_byte;
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_c = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c = scl_s && scl_d && !sda_d && sda_s;

  // byte engine: address byte, ack, then data bytes msb first
  always_comb begin
    next_st = st;
    next_shift = shift;
    next_nbit = nbit;
    next_rd_mode = rd_mode;
    next_sda_drv = sda_drv;
    next_ser_wr = 1'b0;
    if (start_c) begin
      next_st = LNBSC_S_ADDR;
      next_nbit = 4'h0;
      next_sda_drv = 1'b0;
    end else if (stop_c) begin
      next_st = LNBSC_S_IDLE;
      next_sda_drv = 1'b0;
    end else begin
      case (st)
        LNBSC_S_ADDR, LNBSC_S_WR: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s}; // msb first
            next_nbit = nbit + 4'h1;
          end else if (scl_fall && nbit == 4'h8) begin
            next_nbit = 4'h0;
            if (st == LNBSC_S_ADDR) begin
              // four addresses from the strap pins
              if (shift[7:1] == (BASE_ADDR | {5'h00, adsel_s})) begin
                next_sda_drv = 1'b1;
                next_rd_mode = shift[0];
                next_st = LNBSC_S_ACK;
              end else begin
                next_st = LNBSC_S_IDLE;
              end
            end else begin
              next_ser_wr = 1'b1;
              next_sda_drv = 1'b1; // ack each data byte
              next_st = LNBSC_S_ACK;
            end
          end
        end
        LNBSC_S_ACK: begin
          if (scl_fall) begin
            next_nbit = 4'h0;
            if (rd_mode) begin
              next_shift = status_byte; // readback
              next_sda_drv = !status_byte[7];
              next_st = LNBSC_S_RD;
            end else begin
              next_sda_drv = 1'b0;
              next_st = LNBSC_S_WR;
            end
          end
        end
        LNBSC_S_RD: begin
          if (scl_fall) begin
            if (nbit == 4'h7) begin
              next_sda_drv = 1'b0;
              next_st = LNBSC_S_RACK;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_sda_drv = !shift[6];
              next_nbit = nbit + 4'h1;
            end
          end
        end
        LNBSC_S_RACK: begin
          if (scl_rise) begin
            next_st = sda_s ? LNBSC_S_IDLE : LNBSC_S_ACK;
          end
        end
        default: next_st = LNBSC_S_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= LNBSC_S_IDLE;
      shift <= 8'h00;
      nbit <= 4'h0;
      rd_mode <= 1'b0;
      sda_drv <= 1'b0;
      ser_wr <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      st <= next_st;
      shift <= next_shift;
      nbit <= next_nbit;
      rd_mode <= next_rd_mode;
      sda_drv <= next_sda_drv;
      ser_wr <= next_ser_wr;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = sda_drv;

  ////////////////////////////////////////////////////////////////////
  // system control register, six writable bits
  logic ovl_flag, otp_flag;
  always_comb begin
    next_ctrl = ctrl;
    if (ser_wr) begin
      next_ctrl = shift & CTRL_MASK;
    end else if (reg_wr && reg_addr == ADDR_SYS) begin
      next_ctrl = reg_wdata & CTRL_MASK;
    end
  end
  assign status_byte = ctrl | ({7'h00, ovl_flag} << BIT_OVERLOAD)
                            | ({7'h00, otp_flag} << BIT_OVERTEMP);
  logic [7:0] next_rdata;
  always_comb begin
    if (reg_rd && reg_addr == ADDR_SYS) begin
      next_rdata = status_byte;
    end else begin
      next_rdata = 8'h00;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
      reg_rdata <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pulsed current limit timer and protection flags
  lnbsc_pulse_e pst, next_pst;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_ovl_flag, next_otp_flag;
  logic enabled, pulsed, ovl_seen, next_ovl_seen;
  assign enabled = ctrl[BIT_SUPPLY_EN] && !uv_s;
  assign pulsed = !ctrl[BIT_PULSE_MODE];
  always_comb begin
    next_pst = pst;
    next_cnt = cnt;
    next_ovl_seen = ovl_seen;
    next_ovl_flag = ovl_flag;
    if (!enabled || !pulsed) begin
      next_pst = LNBSC_IDLE; // timer held clear
      next_cnt = '0;
      next_ovl_seen = 1'b0;
      next_ovl_flag = enabled && ovl_s; // static flag tracks clamp
    end else begin
      case (pst)
        LNBSC_IDLE: begin
          next_ovl_flag = 1'b0;
          if (ovl_s) begin
            next_pst = LNBSC_OFF; // off and flag together
            next_ovl_flag = 1'b1;
            next_cnt = '0;
          end
        end
        LNBSC_OFF: begin
          next_cnt = cnt + 1'b1; // internal timer
          if ({{(64-CNT_W){1'b0}}, cnt} >= OFF_CYCLES - 1) begin
            next_pst = LNBSC_ON; // on for a tenth
            next_cnt = '0;
            next_ovl_seen = 1'b0;
          end
        end
        LNBSC_ON: begin
          next_cnt = cnt + 1'b1;
          next_ovl_seen = ovl_seen | ovl_s;
          if ({{(64-CNT_W){1'b0}}, cnt} >= ON_CYCLES - 1) begin
            next_cnt = '0;
            if (ovl_seen || ovl_s) begin
              next_pst = LNBSC_OFF; // still overloaded, cycle again
            end else begin
              next_pst = LNBSC_IDLE; // clean on period clears flag
              next_ovl_flag = 1'b0;
            end
          end
        end
        default: next_pst = LNBSC_IDLE;
      endcase
    end
    // thermal hysteresis is in the sensor: high above 150, low below 140
    next_otp_flag = otp_s;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pst <= LNBSC_IDLE;
      cnt <= '0;
      ovl_seen <= 1'b0;
      ovl_flag <= 1'b0;
      otp_flag <= 1'b0;
    end else begin
      pst <= next_pst;
      cnt <= next_cnt;
      ovl_seen <= next_ovl_seen;
      ovl_flag <= next_ovl_flag;
      otp_flag <= next_otp_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // drive to the analog blocks and pins, all registered
  lnbsc_drive_s next_drive;
  logic next_det_oe;
  always_comb begin
    next_drive.power_on = enabled && !otp_s && pst != LNBSC_OFF;
    next_drive.loop_closed = !ctrl[BIT_SUPPLY_EN] && !otp_s && !uv_s;
    next_drive.level_18v = ctrl[BIT_LEVEL_SEL] && !uv_s;
    next_drive.boost_1v = ctrl[BIT_BOOST] && !uv_s;
    next_drive.low_current = ctrl[BIT_CUR_SEL] && !uv_s; // high bit picks low range
    // forced tone wins over the key pin
    next_drive.tone_out = !uv_s && (ctrl[BIT_TONE_ON] || key_s);
    next_det_oe = det_s && !uv_s; // pull low while tone present
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      drive <= '0;
      tone_detect_oe <= 1'b0;
    end else begin
      drive <= next_drive;
      tone_detect_oe <= next_det_oe;
    end
  end
  assign tone_detect_output = 1'b0;
endmodule

// File: test/lnbsc_sva.sv
// checker: port-level assertions for the supply control block
`timescale 1ns/1ps
module lnbsc_sva
  import lnbsc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tone_detector_input,
  input wire logic overload_sense,
  input wire logic overtemp_sense,
  input wire logic undervolt_sense,
  input wire logic tone_detect_oe,
  input wire lnbsc_drive_s drive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // no sense input active, so the written settings alone decide the outputs
  logic calm;
  assign calm = !overload_sense && !overtemp_sense && !undervolt_sense;
  sequence ctl_wr;
    reg_wr && reg_addr == ADDR_SYS && calm;
  endsequence
  sequence settled;
    ctl_wr ##1 (calm && !reg_wr)[*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_RD_UNMAP: assert property (reg_rd && reg_addr != ADDR_SYS |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_READBACK: assert property (ctl_wr ##1 (reg_rd && reg_addr == ADDR_SYS)
    |=> reg_rdata[5:0] == $past(reg_wdata[5:0], 2)) else $error("readback differs");
  AST_STANDBY: assert property (settled |-> drive.power_on == $past(reg_wdata[0], 4)
    && drive.loop_closed == !$past(reg_wdata[0], 4)) else $error("standby state wrong");
  AST_LEVEL: assert property (settled |-> !$past(reg_wdata[0], 4)
    || drive[3:1] == $past({reg_wdata[1], reg_wdata[2], reg_wdata[4]}, 4))
    else $error("level, boost or current select wrong");
  AST_TONE: assert property (settled |-> !$past(reg_wdata[0] && reg_wdata[3], 4)
    || drive.tone_out) else $error("forced tone missing");
  AST_UVLO: assert property (undervolt_sense[*5] |-> drive == '0 && !tone_detect_oe)
    else $error("lockout left something active");
  AST_OTEMP: assert property ((overtemp_sense && !undervolt_sense)[*5]
    |-> !drive.power_on && !drive.loop_closed) else $error("overtemp did not shut off");
  AST_DETECT: assert property ((tone_detector_input && !undervolt_sense)[*5]
    |-> tone_detect_oe) else $error("detect output not pulled low");
  // main scenarios reached
  cover property (settled);
  cover property (undervolt_sense[*5]);
  cover property ($rose(tone_detect_oe));
endmodule
bind lnbsc_top lnbsc_sva u_lnbsc_sva (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .tone_detector_input, .overload_sense, .overtemp_sense, .undervolt_sense,
  .tone_detect_oe, .drive);

// File: test/lnbsc_host.sv
// host model: serial bus master that writes the control byte
`timescale 1ns/1ps
module lnbsc_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // idle bus: clock stands still high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit per 160 ns period; data only moves while the clock is low
  task automatic clk_bit(input logic b, output logic seen);
    sda_low = !b;
    #40 scl = 1'b1;
    #40 seen = sda;
    #40 scl = 1'b0;
    #40;
  endtask
  // start, address byte, data byte, stop; ack is high when the slave acked
  // on a read the data byte is released and q holds what the slave shifted out
  task automatic xfer(input logic [6:0] a, input logic rnw, input logic [7:0] d,
                      output logic ack, output logic [7:0] q);
    logic [17:0] sh;
    logic s;
    #1;
    sh = {a, rnw, 1'b1, rnw ? 8'hff : d, 1'b1};
    ack = 1'b1;
    q = 8'h00;
    sda_low = 1'b1;
    #80 scl = 1'b0;
    #40;
    for (int i = 17; i >= 0; i--) begin
      clk_bit(sh[i], s);
      if (i == 9 || (i == 0 && !rnw)) ack = ack & !s;
      if (i >= 1 && i <= 8) q[i-1] = s;
    end
    sda_low = 1'b1;
    #40 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask
endmodule

// File: test/testbench.sv
// testbench: register port, serial host and protection sequencing
`timescale 1ns/1ps
module testbench;
  import lnbsc_pkg::*;
  typedef struct packed {logic [7:0] w; lnbsc_drive_s e;} lnbsc_row_s;
  logic clock = 0, nrst = 0, reg_wr = 0, reg_rd = 0, ack;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd;
  logic [1:0] addr_select = 2'h0;
  logic tone_key_input = 0, tone_detector_input = 0, overload_sense = 0;
  logic overtemp_sense = 0, undervolt_sense = 0;
  logic scl_in, sda_in, sda_low, sda_out, sda_oe, tone_detect_output, tone_detect_oe;
  lnbsc_drive_s drive;
  int mismatches = 0, n_checks = 0, n;
  lnbsc_row_s rows [7] = '{'{8'h00, 6'h10}, '{8'h01, 6'h20}, '{8'h03, 6'h28},
    '{8'h05, 6'h24}, '{8'h09, 6'h21}, '{8'h11, 6'h22}, '{8'hff, 6'h2f}};
  always #2.5 clock = ~clock;
  // pulled-up data line, low while either party pulls it
  assign sda_in = !(sda_low || (sda_oe && !sda_out));
  lnbsc_top #(.OFF_CYCLES(100), .ON_CYCLES(10)) u_lnbsc_top (.clock, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_in, .sda_in, .sda_out, .sda_oe,
    .addr_select, .tone_key_input, .tone_detector_input, .overload_sense, .overtemp_sense,
    .undervolt_sense, .tone_detect_output, .tone_detect_oe, .drive);
  lnbsc_host u_lnbsc_host (.scl(scl_in), .sda_low, .sda(sda_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // three cycles of input latency, with margin
  task automatic settle();
    repeat (6) @(posedge clock);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk({2'b0, drive}, 8'h10);
    rdr(4'h0);
    chk(rd, 8'h00);
    foreach (rows[i]) begin
      wr(4'h0, rows[i].w);
      settle();
      chk({2'b0, drive}, {2'b0, rows[i].e});
      rdr(4'h0);
      chk(rd, rows[i].w & CTRL_MASK);
    end
    // unmapped place: write ignored, read zero
    wr(4'h7, 8'h00);
    rdr(4'h7);
    chk(rd, 8'h00);
    rdr(4'h0);
    chk(rd, 8'h3f);
    // write then read with no gap between the strobes
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= ADDR_SYS;
    reg_wdata <= 8'h2a;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, 8'h2a);
    // key pin drives the tone while tone force stays low
    wr(4'h0, 8'h01);
    tone_key_input <= 1'b1;
    tone_detector_input <= 1'b1;
    settle();
    chk({6'b0, tone_detect_oe, drive.tone_out}, 8'h03);
    tone_key_input <= 1'b0;
    tone_detector_input <= 1'b0;
    overtemp_sense <= 1'b1;
    settle();
    rdr(4'h0);
    chk({rd[7], 1'b0, drive}, 8'h80);
    overtemp_sense <= 1'b0;
    settle();
    rdr(4'h0);
    chk({rd[7], 1'b0, drive}, 8'h20);
    wr(4'h0, 8'h09);
    undervolt_sense <= 1'b1;
    tone_detector_input <= 1'b1;
    settle();
    chk({1'b0, tone_detect_oe, drive}, 8'h00);
    undervolt_sense <= 1'b0;
    tone_detector_input <= 1'b0;
    // static clamp: flag follows the overload
    wr(4'h0, 8'h21);
    overload_sense <= 1'b1;
    settle();
    rdr(4'h0);
    chk(rd, 8'h61);
    overload_sense <= 1'b0;
    settle();
    rdr(4'h0);
    chk(rd, 8'h21);
    // disabled: overload ignored, loop stays closed, its current is the system's to limit
    wr(4'h0, 8'h00);
    overload_sense <= 1'b1;
    settle();
    rdr(4'h0);
    chk(rd, 8'h00);
    chk({2'b0, drive}, 8'h10);
    // pulsed: off, on, off again while overloaded, then recovery
    wr(4'h0, 8'h01);
    overload_sense <= 1'b1;
    settle();
    rdr(4'h0);
    chk(rd, 8'h41);
    chk({7'b0, drive.power_on}, 8'h00);
    n = 0;
    while (!drive.power_on && n < 1000) begin
      @(posedge clock);
      n++;
    end
    chk({7'b0, n >= 85 && n <= 100}, 8'h01);
    n = 0;
    while (drive.power_on && n < 1000) begin
      @(posedge clock);
      n++;
    end
    chk({7'b0, n >= 5 && n <= 15}, 8'h01);
    overload_sense <= 1'b0;
    repeat (130) @(posedge clock);
    rdr(4'h0);
    chk(rd, 8'h01);
    chk({7'b0, drive.power_on}, 8'h01);
    // serial writes at all four strap addresses, then a foreign address
    for (int s = 0; s < 4; s++) begin
      addr_select <= 2'(s);
      settle();
      u_lnbsc_host.xfer(BASE_ADDR | 7'(s), 1'b0, 8'h10 | 8'(s), ack, rd);
      chk({7'b0, ack}, 8'h01);
      settle();
      rdr(4'h0);
      chk(rd, 8'h10 | 8'(s));
    end
    u_lnbsc_host.xfer(7'h30, 1'b0, 8'h3f, ack, rd);
    chk({7'b0, ack}, 8'h00);
    settle();
    rdr(4'h0);
    chk(rd, 8'h13);
    // serial read-back of the register, master ends it with no ack
    u_lnbsc_host.xfer(BASE_ADDR | 7'h3, 1'b1, 8'hff, ack, rd);
    chk({7'b0, ack}, 8'h01);
    chk(rd, 8'h13);
    // reset in mid-run: settings lost, standby again
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk({2'b0, drive}, 8'h10);
    rdr(4'h0);
    chk(rd, 8'h00);
    tally_and_finish();
  end
  // hang guard: whole run is well under this span
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule
